// ===== pk_pkg.sv
/*
 * Constants and types shared by the public key unit register interface.
 * Assumes APB byte addresses with each register on one aligned 32-bit word.
 */
`default_nettype none

package pk_pkg;

	// Byte addresses on the processor bus
	localparam logic [31:0] ADDR_B_WIN   = 32'h0000_2800;
	localparam logic [31:0] ADDR_A_WIN   = 32'h0000_2900;
	localparam logic [31:0] ADDR_N_WIN   = 32'h0000_2A00;
	localparam logic [31:0] ADDR_EXP_WIN = 32'h0000_2C00;
	localparam logic [31:0] ADDR_CTRL    = 32'h0000_2C04;
	localparam logic [31:0] ADDR_STAT    = 32'h0000_2C08;
	localparam logic [31:0] ADDR_MASK    = 32'h0000_2C0C;
	localparam logic [31:0] ADDR_PC      = 32'h0000_2C14;
	localparam logic [31:0] ADDR_INTERRUPT_CLEAR_COMMAND  = 32'h0000_2C18;
	localparam logic [31:0] ADDR_MODLEN  = 32'h0000_2C1C;
	localparam logic [31:0] ADDR_EXPLEN  = 32'h0000_2C20;
	localparam logic [31:0] ADDR_VERSION = 32'h0000_2C24;

	// Each operand window spans this many 32-bit words
	localparam int WIN_WORDS = 64;
	localparam int WIN_AW    = 6;

	// Operand memory geometry
	localparam int NUM_SUB   = 4;
	localparam int SUB_DEPTH = 32;
	localparam int SUB_W     = 16;
	localparam int SUB_AW    = 5;

	// Control register fields
	localparam int CTRL_NSEL_LSB = 0;
	localparam int CTRL_BSEL_LSB = 2;
	localparam int CTRL_ASEL_LSB = 4;
	localparam int CTRL_RST_BIT  = 10;

	// Status register fields
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_IRQ_BIT  = 2;
	localparam int STAT_CLR_BIT  = 3;

	// Interrupt mask field
	localparam int MASK_DONE_BIT = 0;

	// Reset values
	localparam logic [1:0]  PTR_RST    = 2'h0;
	localparam logic [31:0] MASK_RST   = 32'h0000_0000;
	localparam logic [31:0] PC_RST     = 32'h0000_0000;
	localparam logic [31:0] LEN_RST    = 32'h0000_0000;

	typedef logic [1:0] pk_ptr_t;

endpackage : pk_pkg

`default_nettype wire

// ===== pk_mem_if.sv
/*
 * Link between the register interface and one operand memory.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface pk_mem_if;
	import pk_pkg::*;

	logic                 host_we;
	logic [WIN_AW-1:0]    host_word;
	logic [31:0]          host_wdata;
	logic [31:0]          host_rdata;
	pk_ptr_t              blk_sel;
	logic [SUB_AW-1:0]    eng_addr;
	logic [SUB_W-1:0]     eng_rdata;
	logic                 clr_start;
	logic                 clr_busy;

	modport ctrl (output host_we, host_word, host_wdata, blk_sel,
		eng_addr, clr_start, input host_rdata, eng_rdata, clr_busy);
	modport mem (input host_we, host_word, host_wdata, blk_sel,
		eng_addr, clr_start, output host_rdata, eng_rdata, clr_busy);

endinterface : pk_mem_if

`default_nettype wire

// ===== pk_operand_mem.sv
/*
 * One operand memory: four sub-memories of 32 x 16-bit locations.
 * Assumes host word accesses and an engine read port selected by a pointer.
 */
`timescale 1ns/1ps
`default_nettype none

module pk_operand_mem
	import pk_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Memory link
	pk_mem_if.mem     mif
);

	localparam int HW = NUM_SUB * SUB_DEPTH;

	logic [SUB_W-1:0]  mem_q [0:HW-1];
	logic [SUB_AW-1:0] clr_cnt_q;
	logic              clr_busy_q;
	logic [SUB_W-1:0]  eng_rdata_q;

	// Clear sweep over all locations after a software reset
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			clr_busy_q <= 1'b0;
			clr_cnt_q  <= '0;
		end
		else if (mif.clr_start)
		begin
			clr_busy_q <= 1'b1;
			clr_cnt_q  <= '0;
		end
		else if (clr_busy_q)
		begin
			clr_cnt_q <= clr_cnt_q + 1'b1;
			if (clr_cnt_q == SUB_AW'(SUB_DEPTH - 1))
				clr_busy_q <= 1'b0;
		end
	end

	// Word k holds halfwords 2k and 2k+1; top bits pick the sub-memory
	always_ff @(posedge clk)
	begin
		if (clr_busy_q)
		begin
			for (int s = 0; s < NUM_SUB; s++)
				mem_q[{s[1:0], clr_cnt_q}] <= '0;
		end
		else if (mif.host_we)
		begin
			mem_q[{mif.host_word, 1'b0}] <= mif.host_wdata[15:0];
			mem_q[{mif.host_word, 1'b1}] <= mif.host_wdata[31:16];
		end
	end

	// Engine read through the block pointer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			eng_rdata_q <= '0;
		else
			eng_rdata_q <= mem_q[{mif.blk_sel, mif.eng_addr}];
	end

	assign mif.host_rdata = {mem_q[{mif.host_word, 1'b1}],
		mem_q[{mif.host_word, 1'b0}]};
	assign mif.eng_rdata  = eng_rdata_q;
	assign mif.clr_busy   = clr_busy_q;

endmodule : pk_operand_mem

`default_nettype wire

// ===== pk_unit_regs.sv
/*
 * APB register and memory-window interface of the public key unit.
 * Assumes an APB master on clk and an arithmetic engine on the engine ports.
 */
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pk_unit_regs
	import pk_pkg::*;
#(
	parameter logic [31:0] VERSION_ID = 32'h0000_0A5C, // arbitrary value
	parameter int          PC_W       = 10,
	parameter int          LEN_W      = 12,
	parameter int          EXP_DEPTH  = 64
)
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// Engine side
	input  wire logic [SUB_AW-1:0] eng_addr,
	input  wire logic              eng_done,
	input  wire logic              eng_busy,
	input  wire logic              eng_step,
	output logic [SUB_W-1:0]       eng_a_data,
	output logic [SUB_W-1:0]       eng_b_data,
	output logic [SUB_W-1:0]       eng_n_data,
	output var  pk_pkg::pk_ptr_t   a_ptr,
	output var  pk_pkg::pk_ptr_t   b_ptr,
	output var  pk_pkg::pk_ptr_t   n_ptr,
	output var  logic [PC_W-1:0]   prog_cnt,
	output var  logic [LEN_W-1:0]  mod_len,
	output var  logic [LEN_W-1:0]  exp_len,
	output var  logic              sw_reset,
	output var  logic              irq
);
	import pk_pkg::*;

	localparam int EXP_AW = $clog2(EXP_DEPTH);

	generate
		if (PC_W < 1 || PC_W > 32 || LEN_W < 1 || LEN_W > 32)
			$error("pk_unit_regs: register width out of range");
		if (EXP_DEPTH < 2 || (1 << EXP_AW) != EXP_DEPTH)
			$error("pk_unit_regs: EXP_DEPTH must be a power of two");
	endgenerate

	pk_mem_if a_if ();
	pk_mem_if b_if ();
	pk_mem_if n_if ();

	pk_operand_mem u_amem (.clk(clk), .rstn(rstn), .mif(a_if.mem));
	pk_operand_mem u_bmem (.clk(clk), .rstn(rstn), .mif(b_if.mem));
	pk_operand_mem u_nmem (.clk(clk), .rstn(rstn), .mif(n_if.mem));

	// Address decode on the 12-bit local word address
	logic [11:0] loc;
	logic        in_range;
	logic        sel_a;
	logic        sel_b;
	logic        sel_n;
	logic        sel_exp;
	logic        sel_ctrl;
	logic        sel_stat;
	logic        sel_mask;
	logic        sel_pc;
	logic        sel_clr;
	logic        sel_modlen;
	logic        sel_explen;
	logic        sel_ver;
	logic        mapped;
	logic        wr_en;
	logic        acc_en;

	function automatic logic [11:0] local_of(input logic [31:0] a);
		local_of = a[13:2];
	endfunction : local_of

	assign loc      = paddr[13:2];
	assign in_range = (paddr[31:14] == '0) && (paddr[1:0] == 2'b00);

	assign sel_b      = in_range &&
		(loc >> WIN_AW) == (local_of(ADDR_B_WIN) >> WIN_AW);
	assign sel_a      = in_range &&
		(loc >> WIN_AW) == (local_of(ADDR_A_WIN) >> WIN_AW);
	assign sel_n      = in_range &&
		(loc >> WIN_AW) == (local_of(ADDR_N_WIN) >> WIN_AW);
	assign sel_exp    = in_range && loc == local_of(ADDR_EXP_WIN);
	assign sel_ctrl   = in_range && loc == local_of(ADDR_CTRL);
	assign sel_stat   = in_range && loc == local_of(ADDR_STAT);
	assign sel_mask   = in_range && loc == local_of(ADDR_MASK);
	assign sel_pc     = in_range && loc == local_of(ADDR_PC);
	assign sel_clr    = in_range && loc == local_of(ADDR_INTERRUPT_CLEAR_COMMAND);
	assign sel_modlen = in_range && loc == local_of(ADDR_MODLEN);
	assign sel_explen = in_range && loc == local_of(ADDR_EXPLEN);
	assign sel_ver    = in_range && loc == local_of(ADDR_VERSION);

	assign mapped = sel_a || sel_b || sel_n || sel_exp || sel_ctrl ||
		sel_stat || sel_mask || sel_pc || sel_clr || sel_modlen ||
		sel_explen || sel_ver;

	// Access completes in the first access cycle
	assign acc_en = psel && penable && pready;
	assign wr_en  = acc_en && pwrite && mapped;

	// Registers
	pk_ptr_t           a_ptr_q;
	pk_ptr_t           b_ptr_q;
	pk_ptr_t           n_ptr_q;
	logic              rst_pulse_q;
	logic [31:0]       mask_q;
	logic [PC_W-1:0]   pc_q;
	logic [LEN_W-1:0]  modlen_q;
	logic [LEN_W-1:0]  explen_q;
	logic              done_q;
	logic              pend_q;
	logic              irq_q;
	logic [EXP_AW-1:0] exp_ptr_q;
	logic [31:0]       exp_mem_q [0:EXP_DEPTH-1];
	logic              pready_q;
	logic              pslverr_q;
	logic [31:0]       prdata_q;
	logic [31:0]       ctrl_rd;
	logic [31:0]       stat_rd;

	// APB handshake: answer in the first access cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= psel && !penable;
			pslverr_q <= psel && !penable && !mapped;
		end
	end

	// Control: pointers are static, reset bit is dynamic
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			a_ptr_q     <= PTR_RST;
			b_ptr_q     <= PTR_RST;
			n_ptr_q     <= PTR_RST;
			rst_pulse_q <= 1'b0;
		end
		else if (wr_en && sel_ctrl)
		begin
			n_ptr_q     <= pwdata[CTRL_NSEL_LSB +: 2];
			b_ptr_q     <= pwdata[CTRL_BSEL_LSB +: 2];
			a_ptr_q     <= pwdata[CTRL_ASEL_LSB +: 2];
			rst_pulse_q <= pwdata[CTRL_RST_BIT];
		end
		else if (rst_pulse_q)
		begin
			a_ptr_q     <= PTR_RST;
			b_ptr_q     <= PTR_RST;
			n_ptr_q     <= PTR_RST;
			rst_pulse_q <= 1'b0;
		end
	end

	// Interrupt mask and lengths
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mask_q   <= MASK_RST;
			modlen_q <= LEN_RST[LEN_W-1:0];
			explen_q <= LEN_RST[LEN_W-1:0];
		end
		else if (rst_pulse_q)
		begin
			mask_q   <= MASK_RST;
			modlen_q <= LEN_RST[LEN_W-1:0];
			explen_q <= LEN_RST[LEN_W-1:0];
		end
		else if (wr_en)
		begin
			if (sel_mask)
				mask_q <= pwdata;
			if (sel_modlen)
				modlen_q <= pwdata[LEN_W-1:0];
			if (sel_explen)
				explen_q <= pwdata[LEN_W-1:0];
		end
	end

	// Program counter: host writes, engine steps, reset clears to zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pc_q <= PC_RST[PC_W-1:0];
		else if (rst_pulse_q)
			pc_q <= PC_RST[PC_W-1:0];
		else if (wr_en && sel_pc)
			pc_q <= pwdata[PC_W-1:0];
		else if (eng_step)
			pc_q <= pc_q + 1'b1;
	end

	// Done and pending interrupt: a new event beats a same-cycle clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			done_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else if (rst_pulse_q)
		begin
			done_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else if (eng_done)
		begin
			done_q <= 1'b1;
			pend_q <= 1'b1;
		end
		else if (wr_en && sel_clr)
		begin
			done_q <= 1'b0;
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			irq_q <= 1'b0;
		else
			irq_q <= pend_q && mask_q[MASK_DONE_BIT] && !rst_pulse_q;
	end

	// Exponent memory: one word location, auto-incrementing pointer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			exp_ptr_q <= '0;
		else if (rst_pulse_q || (wr_en && sel_explen))
			exp_ptr_q <= '0;
		else if (acc_en && sel_exp)
			exp_ptr_q <= exp_ptr_q + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (wr_en && sel_exp)
			exp_mem_q[exp_ptr_q] <= pwdata;
	end

	// Read-back images of the control and status words
	always_comb
	begin
		ctrl_rd = '0;
		ctrl_rd[CTRL_NSEL_LSB +: 2] = n_ptr_q;
		ctrl_rd[CTRL_BSEL_LSB +: 2] = b_ptr_q;
		ctrl_rd[CTRL_ASEL_LSB +: 2] = a_ptr_q;
		ctrl_rd[CTRL_RST_BIT]       = rst_pulse_q;
		stat_rd = '0;
		stat_rd[STAT_DONE_BIT] = done_q;
		stat_rd[STAT_BUSY_BIT] = eng_busy;
		stat_rd[STAT_IRQ_BIT]  = pend_q;
		stat_rd[STAT_CLR_BIT]  = a_if.clr_busy;
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			prdata_q <= '0;
		else if (psel && !penable && !pwrite)
		begin
			prdata_q <= '0;
			if (sel_a)
				prdata_q <= a_if.host_rdata;
			if (sel_b)
				prdata_q <= b_if.host_rdata;
			if (sel_n)
				prdata_q <= n_if.host_rdata;
			if (sel_exp)
				prdata_q <= exp_mem_q[exp_ptr_q];
			if (sel_ctrl)
				prdata_q <= ctrl_rd;
			if (sel_stat)
				prdata_q <= stat_rd;
			if (sel_mask)
				prdata_q <= mask_q;
			if (sel_pc)
				prdata_q <= 32'(pc_q);
			if (sel_modlen)
				prdata_q <= 32'(modlen_q);
			if (sel_explen)
				prdata_q <= 32'(explen_q);
			if (sel_ver)
				prdata_q <= VERSION_ID;
		end
	end

	// Operand memory links
	assign a_if.host_we    = wr_en && sel_a && !a_if.clr_busy;
	assign b_if.host_we    = wr_en && sel_b && !b_if.clr_busy;
	assign n_if.host_we    = wr_en && sel_n && !n_if.clr_busy;
	assign a_if.host_word  = loc[WIN_AW-1:0];
	assign b_if.host_word  = loc[WIN_AW-1:0];
	assign n_if.host_word  = loc[WIN_AW-1:0];
	assign a_if.host_wdata = pwdata;
	assign b_if.host_wdata = pwdata;
	assign n_if.host_wdata = pwdata;
	assign a_if.blk_sel    = a_ptr_q;
	assign b_if.blk_sel    = b_ptr_q;
	assign n_if.blk_sel    = n_ptr_q;
	assign a_if.eng_addr   = eng_addr;
	assign b_if.eng_addr   = eng_addr;
	assign n_if.eng_addr   = eng_addr;
	assign a_if.clr_start  = rst_pulse_q;
	assign b_if.clr_start  = rst_pulse_q;
	assign n_if.clr_start  = rst_pulse_q;

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign eng_a_data = a_if.eng_rdata;
	assign eng_b_data = b_if.eng_rdata;
	assign eng_n_data = n_if.eng_rdata;
	assign a_ptr      = a_ptr_q;
	assign b_ptr      = b_ptr_q;
	assign n_ptr      = n_ptr_q;
	assign prog_cnt   = pc_q;
	assign mod_len    = modlen_q;
	assign exp_len    = explen_q;
	assign sw_reset   = rst_pulse_q;
	assign irq        = irq_q;

endmodule : pk_unit_regs

`default_nettype wire

// ===== pk_unit_regs_props.sv
/*
 Property checker for pk_unit_regs, bound to its ports.
 Assumes an APB master that holds its request until pready.
*/
`timescale 1ns/1ps
`default_nettype none
module pk_unit_regs_props
	import pk_pkg::*;
#(
	parameter logic [31:0] VERSION_ID = 32'h0000_0A5C, // Arbitrary value
	parameter int          PC_W       = 10,
	parameter int          LEN_W      = 12
)
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             rstn,
	// APB
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [31:0]      paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	// Engine side
	input wire logic             eng_step,
	input wire pk_pkg::pk_ptr_t  a_ptr,
	input wire pk_pkg::pk_ptr_t  b_ptr,
	input wire pk_pkg::pk_ptr_t  n_ptr,
	input wire logic [PC_W-1:0]  prog_cnt,
	input wire logic [LEN_W-1:0] mod_len,
	input wire logic             sw_reset
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	logic [31:0] wd_q;
	wire logic   wr_acc = psel && penable && pwrite && pready;

	// Write data of the access just taken
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			wd_q <= 32'h0000_0000;
		else
			wd_q <= pwdata;

	ready_first_a: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	ready_only_a: assert property (pready |-> psel && penable)
		else $error("pready outside access cycle");
	misalign_err_a: assert property (psel && !penable &&
		paddr[1:0] != 2'b00 |=> pready && pslverr)
		else $error("misaligned access not refused");
	ptr_load_a: assert property (wr_acc &&
		paddr == ADDR_CTRL && !pwdata[CTRL_RST_BIT] |=>
		{a_ptr, b_ptr, n_ptr} == wd_q[5:0])
		else $error("block pointers not loaded");
	rst_pulse_a: assert property (wr_acc && paddr == ADDR_CTRL &&
		pwdata[CTRL_RST_BIT] |=> sw_reset ##1 !sw_reset)
		else $error("software reset not a one cycle pulse");
	rst_clear_a: assert property (sw_reset |=> a_ptr == 2'h0 &&
		b_ptr == 2'h0 && n_ptr == 2'h0 && prog_cnt == '0 && mod_len == '0)
		else $error("software reset left state behind");
	len_load_a: assert property (wr_acc && paddr == ADDR_MODLEN
		|=> mod_len == wd_q[LEN_W-1:0])
		else $error("modulus length not loaded");
	pc_load_a: assert property (wr_acc && paddr == ADDR_PC && !eng_step
		|=> prog_cnt == wd_q[PC_W-1:0])
		else $error("program counter not loaded");
	version_a: assert property (psel && !penable && !pwrite &&
		paddr == ADDR_VERSION |=> prdata == VERSION_ID && !pslverr)
		else $error("version code wrong");
endmodule : pk_unit_regs_props

bind pk_unit_regs pk_unit_regs_props #(.VERSION_ID(VERSION_ID), .PC_W(PC_W),
	.LEN_W(LEN_W)) pk_unit_regs_props_i (.clk(clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.eng_step(eng_step), .a_ptr(a_ptr), .b_ptr(b_ptr), .n_ptr(n_ptr),
	.prog_cnt(prog_cnt), .mod_len(mod_len), .sw_reset(sw_reset));
`default_nettype wire

// ===== pk_host_model.sv
/*
 Host processor model: an APB master with one transfer task.
 Assumes the bench calls xfer from a single process.
*/
`timescale 1ns/1ps
`default_nettype none
module pk_host_model (
	// Clock
	input  wire logic        clk,
	// APB master
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [31:0] paddr,
	output var  logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
	end

	task automatic xfer(input logic w, input logic [31:0] a, d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench watchdog ends a wait that never answers
		do
			@(posedge clk);
		while (!pready);
		r = prdata;
		e = pslverr;
		// Released bus shows the inverse so stale values never match
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : pk_host_model
`default_nettype wire

// ===== tb_pk_unit_regs.sv
/*
 Self-checking bench for pk_unit_regs: registers, windows, interrupt.
 Assumes pk_host_model as master and the bound property checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pk_unit_regs;
	import pk_pkg::*;
	localparam logic [31:0] VID  = 32'h0000_3C5A; // Arbitrary code
	localparam int          PCW  = 10;
	localparam int          LENW = 12;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic              psel, penable, pwrite, pready, pslverr, swr, irq, er;
	logic [31:0]       paddr, pwdata, prdata, rv, s0;
	logic [SUB_AW-1:0] eng_addr = '0;
	logic              eng_done = 1'b0;
	logic              eng_busy = 1'b0;
	logic              eng_step = 1'b0;
	logic [SUB_W-1:0]  a_d, b_d, n_d;
	pk_ptr_t           a_ptr, b_ptr, n_ptr;
	logic [PCW-1:0]    pc;
	logic [LENW-1:0]   mlen, elen;
	logic [31:0]       wv [3];
	logic [31:0]       ra [4] = '{ADDR_MASK, ADDR_PC, ADDR_MODLEN, ADDR_EXPLEN};
	int                rw [4] = '{32, PCW, LENW, LENW};
	logic [31:0]       wb [3] = '{ADDR_A_WIN, ADDR_B_WIN, ADDR_N_WIN};
	int                error_cnt = 0;
	int                tests_run = 0;

	always #20 clk = ~clk;

	pk_host_model pk_host_model_i (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	pk_unit_regs #(.VERSION_ID(VID), .PC_W(PCW), .LEN_W(LENW))
		pk_unit_regs_i (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.eng_addr(eng_addr), .eng_done(eng_done), .eng_busy(eng_busy),
		.eng_step(eng_step), .eng_a_data(a_d), .eng_b_data(b_d),
		.eng_n_data(n_d), .a_ptr(a_ptr), .b_ptr(b_ptr), .n_ptr(n_ptr),
		.prog_cnt(pc), .mod_len(mlen), .exp_len(elen), .sw_reset(swr),
		.irq(irq));

	task automatic chk(input string nm, input logic [31:0] ex, got);
		tests_run++;
		if (got !== ex)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, d);
		pk_host_model_i.xfer(1'b1, a, d, rv, er);
	endtask : wr
	task automatic rd(input logic [31:0] a);
		pk_host_model_i.xfer(1'b0, a, 32'h0000_0000, rv, er);
	endtask : rd
	// Window word of pair p in sub-memory s
	function automatic logic [31:0] win(input logic [31:0] b, input int s, p);
		return b + 32'(4 * ((s % 4) * 16 + p));
	endfunction : win
	function automatic logic [31:0] msk(input logic [31:0] d, input int w);
		return d & (32'hFFFF_FFFF >> (32 - w));
	endfunction : msk
	task automatic pulse(input logic stp);
		@(posedge clk);
		eng_step <= stp;
		eng_done <= !stp;
		@(posedge clk);
		eng_step <= 1'b0;
		eng_done <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic eng_rd(input int a);
		@(posedge clk);
		eng_addr <= SUB_AW'(a);
		repeat (2) @(posedge clk);
	endtask : eng_rd
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	initial
	begin
		#(40 * 20000);
		error_cnt++;
		close_out();
	end

	initial
	begin
		int p;
		void'($urandom(32'h0000_c27b));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		wr(ADDR_CTRL, 32'h0000_0400);
		rd(ADDR_CTRL);
		chk("ctrl after reset", 32'h0000_0000, rv);
		rd(ADDR_STAT);
		chk("clear busy", 32'h1, 32'(rv[STAT_CLR_BIT]));
		for (int n = 0; n < 20 && rv[STAT_CLR_BIT]; n++)
			rd(ADDR_STAT);
		chk("clear done", 32'h0, 32'(rv[STAT_CLR_BIT]));
		rd(win(ADDR_N_WIN, 3, 15));
		chk("cleared window", 32'h0000_0000, rv);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			rd(ra[i]);
			chk("reg reset", 32'h0000_0000, rv);
			repeat (3)
			begin
				s0 = $urandom();
				wr(ra[i], s0);
				rd(ra[i]);
				chk("reg rw", msk(s0, rw[i]), rv);
			end
		end
		repeat (4)
		begin
			s0 = $urandom() & 32'hFFFF_FBFF;
			wr(ADDR_CTRL, s0);
			rd(ADDR_CTRL);
			chk("ctrl rb", s0 & 32'h0000_003F, rv);
			chk("ptrs", 32'(s0[5:0]), 32'({a_ptr, b_ptr, n_ptr}));
		end
		$display("test registers done");
		for (int s = 0; s < 4; s++)
		begin
			p = $urandom_range(15, 0);
			for (int m = 0; m < 3; m++)
			begin
				wv[m] = $urandom();
				wr(win(wb[m], s + m, p), wv[m]);
				rd(win(wb[m], s + m, p));
				chk("window rb", wv[m], rv);
			end
			wr(ADDR_CTRL, {26'h0, 2'(s), 2'(s + 1), 2'(s + 2)});
			for (int h = 0; h < 2; h++)
			begin
				eng_rd(2 * p + h);
				chk("a data", 32'(wv[0][16*h +: 16]), 32'(a_d));
				chk("b data", 32'(wv[1][16*h +: 16]), 32'(b_d));
				chk("n data", 32'(wv[2][16*h +: 16]), 32'(n_d));
			end
		end
		wr(ADDR_EXPLEN, 32'h0000_0100);
		wr(ADDR_EXP_WIN, wv[0]);
		chk("exp len", 32'h0000_0100, 32'(elen));
		wr(ADDR_EXP_WIN, wv[1]);
		wr(ADDR_EXPLEN, 32'h0000_0100);
		rd(ADDR_EXP_WIN);
		chk("exp word0", wv[0], rv);
		rd(ADDR_EXP_WIN);
		chk("exp word1", wv[1], rv);
		$display("test memories done");
		wr(ADDR_MASK, 32'h0000_0001);
		pulse(1'b0);
		chk("irq on", 32'h1, 32'(irq));
		rd(ADDR_STAT);
		chk("pending", 32'h1, 32'(rv[STAT_IRQ_BIT]));
		wr(ADDR_INTERRUPT_CLEAR_COMMAND, $urandom());
		repeat (3) @(posedge clk);
		chk("irq off", 32'h0, 32'(irq));
		rd(ADDR_INTERRUPT_CLEAR_COMMAND);
		chk("clear reads zero", 32'h0000_0000, rv);
		wr(ADDR_MASK, 32'h0000_0000);
		pulse(1'b0);
		chk("irq masked", 32'h0, 32'(irq));
		wr(ADDR_INTERRUPT_CLEAR_COMMAND, 32'h0000_0000);
		$display("test interrupt done");
		eng_busy <= 1'b1;
		rd(ADDR_STAT);
		chk("busy", 32'h1, 32'(rv[STAT_BUSY_BIT]));
		s0 = rv;
		wr(ADDR_STAT, ~s0);
		rd(ADDR_STAT);
		chk("status ro", 32'h0000_0002, rv);
		wr(ADDR_VERSION, ~VID);
		rd(32'h0000_0B09 << 2);
		chk("version", VID, rv);
		rd(32'h0000_2C10);
		chk("unmapped", 32'h1, 32'(er));
		rd(ADDR_CTRL + 32'h0000_0002);
		chk("misaligned", 32'h1, 32'(er));
		s0 = $urandom();
		wr(ADDR_PC, s0);
		pulse(1'b1);
		rd(ADDR_PC);
		chk("pc step", msk(s0 + 32'h1, PCW), rv);
		$display("test status done");
		// Software reset in mid-run with A and N pointers and PC nonzero
		wr(ADDR_CTRL, 32'h0000_0400);
		rd(ADDR_PC);
		chk("pc after sw reset", 32'h0000_0000, rv);
		chk("ptrs after sw reset", 32'h0, 32'({a_ptr, b_ptr, n_ptr}));
		$display("test soft reset done");
		close_out();
	end
endmodule : tb_pk_unit_regs
`default_nettype wire
